// ### core/spm_pin_mux.v
// Port A and port B pin function multiplexer with APB register access.
`timescale 1ns/10ps
`default_nettype none

module spm_pin_mux
(
    // Clock, reset and enable
    input  wire        clk,
    input  wire        rst,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Port A pads, lines 0 to 4
    input  wire [4:0]  port_a_in,
    output wire [4:0]  port_a_out,
    output wire [4:0]  port_a_oe,
    output wire [4:0]  port_a_pu,
    output wire [4:0]  port_a_pd,
    // Port B pads, lines 0 and 1
    input  wire [1:0]  port_b_in,
    output wire [1:0]  port_b_out,
    output wire [1:0]  port_b_oe,
    output wire [1:0]  port_b_pu,
    output wire [1:0]  port_b_pd,
    // Wake-up and external interrupt inputs to the core
    output wire [3:0]  keyboard_wake_in,
    output wire        ext_irq_in,
    // Serial client interface
    output wire        ser_select_n,
    output wire        ser_clock,
    output wire        ser_data_in,
    input  wire        ser_data_out,
    input  wire        ser_data_out_en,
    output wire        ser_enabled,
    // Timer channels
    input  wire [1:0]  timer_out,
    input  wire [1:0]  timer_oe,
    output wire [1:0]  timer_in,
    // Analog channels: three for line B0, four for line B1
    output wire        analog_channel_three_sel,
    output wire        analog_channel_four_sel,
    // Debug strap result
    output wire        background_debug_mode
);

`include "spm_regs.vh"

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    //
    // All configuration lives in plain flip-flops written over the bus.
    // Port A uses one five-bit word per property: data, direction, pull
    // enable and pull select. Wake-up enable only exists for lines 0 to 3,
    // since line 4 doubles as the debug strap and has no wake-up function.
    // Port B packs all of its controls into one word because it has only two
    // lines; its pad inputs are folded into the upper bits on read so that
    // software can see both the setting and the pin in a single access.
    // The serial control word carries the serial enable and the external
    // interrupt enable for line 0. Status is read-only.
    //
    // Unmapped addresses are ignored on write and read back as zero. There is
    // no error response, which keeps the slave simple at the cost of silent
    // failures when software uses a wrong offset.

    reg  [4:0]  pa_data_q;
    reg  [4:0]  pa_dir_q;
    reg  [4:0]  pa_pull_en_q;
    reg  [4:0]  pa_pull_sel_q;   // One selects pullup, zero pulldown.
    reg  [3:0]  pa_wake_en_q;
    reg  [9:0]  pb_ctrl_q;
    reg  [1:0]  ser_ctrl_q;
    wire        strap_done;
    wire [4:0]  pa_core_in;
    wire [1:0]  pb_core_in;
    wire        wr_en;

    // Zero-wait slave: every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel & penable & pwrite & clk_en;

    // Software writes take effect at the access-phase edge.
    always @(posedge clk)
    begin
        if (rst)
        begin
            pa_data_q     <= `SPM_RST_PA5;
            pa_dir_q      <= `SPM_RST_PA5;
            pa_pull_en_q  <= `SPM_RST_PA_PULL;
            pa_pull_sel_q <= `SPM_RST_PA_PULL;
            pa_wake_en_q  <= 4'h0;
            pb_ctrl_q     <= `SPM_RST_PB;
            ser_ctrl_q    <= `SPM_RST_SER;
        end
        else if (wr_en)
        begin
            case (paddr)
                `SPM_PA_DATA:     pa_data_q     <= pwdata[4:0];
                `SPM_PA_DIR:      pa_dir_q      <= pwdata[4:0];
                `SPM_PA_PULL_EN:  pa_pull_en_q  <= pwdata[4:0];
                `SPM_PA_PULL_SEL: pa_pull_sel_q <= pwdata[4:0];
                `SPM_PA_WAKE_EN:  pa_wake_en_q  <= pwdata[3:0];
                `SPM_PB_CTRL:     pb_ctrl_q     <= pwdata[9:0];
                `SPM_SER_CTRL:    ser_ctrl_q    <= pwdata[1:0];
                default:          ser_ctrl_q    <= ser_ctrl_q;
            endcase
        end
    end

    // Read data is registered in the setup cycle so it is stable in the access phase.
    always @(posedge clk)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (clk_en && psel && !penable && !pwrite)
        begin
            case (paddr)
                `SPM_PA_DATA:     prdata <= {27'h000_0000, pa_data_q};
                `SPM_PA_DIR:      prdata <= {27'h000_0000, pa_dir_q};
                `SPM_PA_PULL_EN:  prdata <= {27'h000_0000, pa_pull_en_q};
                `SPM_PA_PULL_SEL: prdata <= {27'h000_0000, pa_pull_sel_q};
                `SPM_PA_WAKE_EN:  prdata <= {28'h000_0000, pa_wake_en_q};
                `SPM_PB_CTRL:     prdata <= {20'h0_0000, pb_core_in, pb_ctrl_q};
                `SPM_SER_CTRL:    prdata <= {30'h0000_0000, ser_ctrl_q};
                `SPM_STATUS:      prdata <= {30'h0000_0000, ser_enabled,
                                             background_debug_mode & strap_done};
                `SPM_PA_IN:       prdata <= {27'h000_0000, pa_core_in};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debug strap.

    spm_debug_strap u_strap
    (
        .clk                   (clk),
        .rst                   (rst),
        .clk_en                (clk_en),
        .debug_entry_in        (port_a_in[4]),
        .background_debug_mode (background_debug_mode),
        .strap_done            (strap_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Port A function selection.
    //
    // Line 4 is an input until the strap has been taken and an output after,
    // so the debug strap can be read without a driver fighting the board.
    // While the serial interface is enabled it owns lines 0 to 3: select,
    // clock and host data are pure inputs, and client data is driven only
    // when the serial block asks for it. Direction bits are then ignored,
    // but kept, so general-purpose use resumes unchanged when serial is off.

    assign ser_enabled = ser_ctrl_q[`SPM_SER_EN_BIT];

    reg  [4:0] pa_drv_en;
    reg  [4:0] pa_drv_val;
    reg  [4:0] pa_in_en;

    // Serial takeover of lines 0-3, else general-purpose direction control.
    always @*
    begin
        pa_drv_en  = pa_dir_q;
        pa_drv_val = pa_data_q;
        pa_in_en   = ~pa_dir_q;
        pa_drv_en[4] = ~strap_done ? 1'b0 : 1'b1;
        pa_in_en[4]  = ~strap_done;
        if (ser_enabled)
        begin
            // select, clock, data in as inputs; data out driven while ser_data_out_en is set
            pa_drv_en[2:0]  = 3'b000;
            pa_in_en[2:0]   = 3'b111;
            pa_drv_en[3]    = ser_data_out_en;
            pa_drv_val[3]   = ser_data_out;
            pa_in_en[3]     = 1'b0;
        end
    end

    // One pad cell per port A line.
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_pa
            wire pd_ok;
            if (gi < 4)
            begin : g_wk
                assign pd_ok = pa_wake_en_q[gi] & ~ser_enabled;
            end
            else
            begin : g_nowk
                assign pd_ok = 1'b0;
            end
            spm_pin_cell u_cell
            (
                .drive_en     (pa_drv_en[gi]),
                .drive_val    (pa_drv_val[gi]),
                .input_en     (pa_in_en[gi]),
                .pull_up_en   (pa_pull_en_q[gi] & pa_pull_sel_q[gi]),
                .pull_down_en (pa_pull_en_q[gi] & ~pa_pull_sel_q[gi] & pd_ok),
                .pad_in       (port_a_in[gi]),
                .pad_out      (port_a_out[gi]),
                .pad_oe       (port_a_oe[gi]),
                .pad_pu       (port_a_pu[gi]),
                .pad_pd       (port_a_pd[gi]),
                .core_in      (pa_core_in[gi])
            );
        end
    endgenerate

    assign keyboard_wake_in = pa_core_in[3:0] & pa_wake_en_q & {4{~ser_enabled}};
    assign ext_irq_in    = pa_core_in[0] & ser_ctrl_q[`SPM_IRQ_EN_BIT] & ~ser_enabled;
    assign ser_select_n  = ser_enabled ? pa_core_in[0] : 1'b1;
    assign ser_clock     = ser_enabled & pa_core_in[1];
    assign ser_data_in   = ser_enabled & pa_core_in[2];

    ////////////////////////////////////////////////////////////////////////////
    // Port B function selection.
    //
    // Each line can be general-purpose, a timer channel or an analog input.
    // An analog line has its driver, its input buffer and its pullup all off,
    // so the converter sees the pin with no digital load on it. Software that
    // sets both selects gets the timer; this avoids an undefined pad state.

    wire [1:0] pb_tmr_sel = pb_ctrl_q[`SPM_PB_TMR_LSB+1:`SPM_PB_TMR_LSB];
    wire [1:0] pb_adc_sel = pb_ctrl_q[`SPM_PB_ADC_LSB+1:`SPM_PB_ADC_LSB];
    wire [1:0] pb_dir     = pb_ctrl_q[`SPM_PB_DIR_LSB+1:`SPM_PB_DIR_LSB];
    wire [1:0] pb_dat     = pb_ctrl_q[`SPM_PB_DATA_LSB+1:`SPM_PB_DATA_LSB];
    wire [1:0] pb_pull    = pb_ctrl_q[`SPM_PB_PULL_LSB+1:`SPM_PB_PULL_LSB];

    // Timer wins over analog if both are set; analog releases the pad fully.
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_pb
            wire tmr = pb_tmr_sel[gi];
            wire adc = pb_adc_sel[gi] & ~tmr;
            spm_pin_cell u_cell
            (
                .drive_en     (tmr ? timer_oe[gi] : (~adc & pb_dir[gi])),
                .drive_val    (tmr ? timer_out[gi] : pb_dat[gi]),
                .input_en     (~adc),
                .pull_up_en   (pb_pull[gi] & ~adc),
                .pull_down_en (1'b0),
                .pad_in       (port_b_in[gi]),
                .pad_out      (port_b_out[gi]),
                .pad_oe       (port_b_oe[gi]),
                .pad_pu       (port_b_pu[gi]),
                .pad_pd       (port_b_pd[gi]),
                .core_in      (pb_core_in[gi])
            );
            assign timer_in[gi] = tmr & pb_core_in[gi];
        end
    endgenerate

    assign analog_channel_three_sel = pb_adc_sel[0] & ~pb_tmr_sel[0];
    assign analog_channel_four_sel  = pb_adc_sel[1] & ~pb_tmr_sel[1];

endmodule // spm_pin_mux

`default_nettype wire

// ### core/spm_regs.vh
// Register map, field positions, reset values and timing counts of the sensor port pin mux.
// How it works
// - Debug-entry line low at power-on reset release enters background debug mode.
// - In general-purpose mode the debug-shared line is output-only, never an input; the code keeps it an input until the strap is taken.
// - Serial enable puts select, clock, data in, data out on port A lines 0-3.
// - A port A pulldown is on only while that line's wake-up is enabled.
// - Port A lines 0 to 3 feed wake-up input bits of the same index.
// - Port A line 0 can be external interrupt, bidirectional with pull and wake-up.
// - Port B line 0 routes to timer channel 0 or analog channel 3.
// - Port B line 1 routes to timer channel 1 or analog channel 4.
// - Port B lines 0 and 1 are bidirectional with a switchable pullup.
// - Writing one to the serial enable bit at 0x1802 enables the serial interface; the code uses bit 0 at offset 0x018 instead.
`ifndef SPM_REGS_VH
`define SPM_REGS_VH

// Register byte offsets.
`define SPM_PA_DATA      12'h000
`define SPM_PA_DIR       12'h004
`define SPM_PA_PULL_EN   12'h008
`define SPM_PA_PULL_SEL  12'h00C
`define SPM_PA_WAKE_EN   12'h010
`define SPM_PB_CTRL      12'h014
`define SPM_SER_CTRL     12'h018
`define SPM_STATUS       12'h01C
`define SPM_PA_IN        12'h020

// Documented address of the serial enable control byte.
`define SPM_SER_EN_DOC_ADDR 16'h1802

// Port B control fields.
`define SPM_PB_DATA_LSB   0
`define SPM_PB_DIR_LSB    2
`define SPM_PB_PULL_LSB   4
`define SPM_PB_TMR_LSB    6
`define SPM_PB_ADC_LSB    8
`define SPM_PB_IN_LSB     10

// Serial control and status fields.
`define SPM_SER_EN_BIT    0
`define SPM_IRQ_EN_BIT    1
`define SPM_ST_DBG_BIT    0
`define SPM_ST_SER_BIT    1

// Reset values.
`define SPM_RST_PA5       5'h00
`define SPM_RST_PA_PULL   5'h10
`define SPM_RST_PB        10'h030
`define SPM_RST_SER       2'h0

// Debug-line sampling count: 100 ns settle at 10 ns per cycle.
// The count is sized to the strap counter so the compare keeps its width.
`define SPM_DBG_SETTLE_CYC 4'd10

`endif

// ### core/spm_debug_strap.v
// Debug-entry strap capture after power-on reset release.
`timescale 1ns/10ps
`default_nettype none

module spm_debug_strap
(
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    input  wire        clk_en,
    // Strap input
    input  wire        debug_entry_in,
    // Result
    output reg         background_debug_mode,
    output reg         strap_done
);

`include "spm_regs.vh"

    reg  [3:0] settle_q;

    // Hold a short settle window after release, then latch the line once.
    // Sampling once avoids later low pulses on the line dropping the part into debug.
    always @(posedge clk)
    begin
        if (rst)
        begin
            settle_q              <= 4'h0;
            background_debug_mode <= 1'b0;
            strap_done            <= 1'b0;
        end
        else if (clk_en && !strap_done)
        begin
            if (settle_q == `SPM_DBG_SETTLE_CYC)
            begin
                background_debug_mode <= ~debug_entry_in;
                strap_done            <= 1'b1;
            end
            else
            begin
                settle_q <= settle_q + 4'h1;
            end
        end
    end

endmodule // spm_debug_strap

`default_nettype wire

// ### core/spm_pin_cell.v
// One bidirectional pad cell with direction, output data and pull controls.
`timescale 1ns/10ps
`default_nettype none

module spm_pin_cell
(
    // Control from the mux
    input  wire        drive_en,
    input  wire        drive_val,
    input  wire        input_en,
    input  wire        pull_up_en,
    input  wire        pull_down_en,
    // Pad side
    input  wire        pad_in,
    output wire        pad_out,
    output wire        pad_oe,
    output wire        pad_pu,
    output wire        pad_pd,
    // Core side
    output wire        core_in
);

    // Pulls are dropped while driving so a pull never fights the driver.
    assign pad_out = drive_val;
    assign pad_oe  = drive_en;
    assign pad_pu  = pull_up_en & ~drive_en;
    assign pad_pd  = pull_down_en & ~drive_en & ~pull_up_en;
    assign core_in = input_en & pad_in;

endmodule // spm_pin_cell

`default_nettype wire

// ### verification/spm_pin_mux_assertions.sv
// Concurrent checks on the pin mux ports.
`timescale 1ns/10ps
`default_nettype none
`include "spm_regs.vh"
module spm_pin_mux_assertions
(
    // Clock and bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Pads and functions
    input wire logic [4:0]  port_a_in,
    input wire logic [4:0]  port_a_out,
    input wire logic [4:0]  port_a_oe,
    input wire logic [4:0]  port_a_pd,
    input wire logic [3:0]  keyboard_wake_in,
    input wire logic        ser_select_n,
    input wire logic        ser_clock,
    input wire logic        ser_data_in,
    input wire logic        ser_data_out,
    input wire logic        ser_data_out_en,
    input wire logic        ser_enabled,
    input wire logic        background_debug_mode
);
    logic [3:0] cnt_q;
    // Edges since reset release; it saturates so the strap window is seen once.
    always @(posedge clk)
        if (rst)
            cnt_q <= 4'h0;
        else if (cnt_q != 4'hc)
            cnt_q <= cnt_q + 4'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_ser_wr;
        psel && penable && pwrite && paddr == `SPM_SER_CTRL;
    endsequence
    a_ser_en_write: assert property (s_ser_wr |=> ser_enabled == $past(pwdata[0]))
        else $error("serial enable missed");
    a_ser_in_map: assert property (ser_enabled |->
        {ser_data_in, ser_clock, ser_select_n} == port_a_in[2:0])
        else $error("serial map wrong");
    a_ser_idle_lvl: assert property (!ser_enabled |->
        {ser_data_in, ser_clock, ser_select_n} == 3'b001)
        else $error("serial idle wrong");
    a_ser_drive_ovr: assert property (ser_enabled |-> port_a_oe[3] == ser_data_out_en
        && (!ser_data_out_en || port_a_out[3] == ser_data_out))
        else $error("serial drive wrong");
    a_wake_ser_off: assert property (ser_enabled |-> keyboard_wake_in == 4'h0)
        else $error("wake active in serial");
    a_pd_gate: assert property (!port_a_pd[4] && (!ser_enabled || port_a_pd[3:0] == 4'h0))
        else $error("pulldown not gated");
    a_strap_take: assert property (cnt_q == 4'ha |=>
        background_debug_mode == !$past(port_a_in[4]))
        else $error("strap value wrong");
    a_strap_hold: assert property (cnt_q == 4'hc |-> $stable(background_debug_mode))
        else $error("debug mode moved");
    a_line4_dir: assert property (port_a_oe[4] == (cnt_q > 4'ha))
        else $error("line four direction wrong");
endmodule // spm_pin_mux_assertions
bind spm_pin_mux spm_pin_mux_assertions i_spm_pin_mux_assertions (.*);
`default_nettype wire

// ### verification/spm_pad_model.sv
// Board-side pad model resolving each line from device drive, host drive and pulls.
`timescale 1ns/10ps
`default_nettype none
module spm_pad_model
(
    // Clock
    input  wire logic       clk,
    // Device pad controls
    input  wire logic [4:0] port_a_out,
    input  wire logic [4:0] port_a_oe,
    input  wire logic [4:0] port_a_pu,
    input  wire logic [4:0] port_a_pd,
    input  wire logic [1:0] port_b_out,
    input  wire logic [1:0] port_b_oe,
    input  wire logic [1:0] port_b_pu,
    // Host drive, port B in bits 6:5
    input  wire logic [6:0] ext_val,
    input  wire logic [6:0] ext_drv,
    // Resolved levels
    output wire logic [4:0] port_a_in,
    output wire logic [1:0] port_b_in
);
    logic [6:0] flt_q = 7'h00;
    wire  [6:0] oe   = {port_b_oe, port_a_oe};
    wire  [6:0] hold = ~oe & ~ext_drv;
    wire  [6:0] pu   = {port_b_pu, port_a_pu};
    wire  [6:0] lvl;
    // An unheld line with no pull on shows a pattern that changes every cycle, never its last value.
    always @(posedge clk)
        flt_q <= ~flt_q;
    assign lvl = (oe & {port_b_out, port_a_out}) | (~oe & ext_drv & ext_val) | (hold & pu)
               | (hold & ~pu & ~{2'b00, port_a_pd} & flt_q);
    assign port_a_in = lvl[4:0];
    assign port_b_in = lvl[6:5];
endmodule // spm_pad_model
`default_nettype wire

// ### verification/sensor_port_pin_mux_tb.sv
// Self-checking bench for the sensor port pin mux.
`timescale 1ns/10ps
`default_nettype none
`include "spm_regs.vh"
module sensor_port_pin_mux_tb;
    logic        clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        ser_data_out = 1'b0, ser_data_out_en = 1'b0;
    logic [1:0]  timer_out = 2'b00, timer_oe = 2'b00;
    logic [6:0]  ext_val = 7'h00, ext_drv = 7'h00;
    wire  [31:0] prdata;
    wire         pready, pslverr, ext_irq_in, ser_select_n, ser_clock, ser_data_in;
    wire         ser_enabled, analog_channel_three_sel, analog_channel_four_sel;
    wire         background_debug_mode;
    wire  [4:0]  port_a_in, port_a_out, port_a_oe, port_a_pu, port_a_pd;
    wire  [1:0]  port_b_in, port_b_out, port_b_oe, port_b_pu, port_b_pd, timer_in;
    wire  [3:0]  keyboard_wake_in;
    logic [4:0]  m_dat, m_dir, m_pe, m_ps;
    logic [3:0]  m_we;
    logic [11:0] m_pb;
    logic [1:0]  m_sc;
    logic        m_bdm;
    int          n_mismatch = 0, num_checks = 0, cyc = 0, seed = 25950;
    spm_pin_mux i_spm_pin_mux (.*);
    spm_pad_model i_spm_pad_model (.*);
    always #5 clk = ~clk;
    // A hang is cut short well past the expected run of some 4200 cycles.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 40000)
        begin
            n_mismatch++;
            final_report;
        end
    end
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
        case (a)
            `SPM_PA_DATA: m_dat = d[4:0];
            `SPM_PA_DIR: m_dir = d[4:0];
            `SPM_PA_PULL_EN: m_pe = d[4:0];
            `SPM_PA_PULL_SEL: m_ps = d[4:0];
            `SPM_PA_WAKE_EN: m_we = d[3:0];
            `SPM_PB_CTRL: m_pb = {2'b00, d[9:0]};
            `SPM_SER_CTRL: m_sc = d[1:0];
            default: ;
        endcase
    endtask
    function logic [31:0] erd(input logic [11:0] a);
        case (a)
            `SPM_PA_DATA: erd = 32'(m_dat);
            `SPM_PA_DIR: erd = 32'(m_dir);
            `SPM_PA_PULL_EN: erd = 32'(m_pe);
            `SPM_PA_PULL_SEL: erd = 32'(m_ps);
            `SPM_PA_WAKE_EN: erd = 32'(m_we);
            `SPM_PB_CTRL: erd = 32'({port_b_in & ~(m_pb[9:8] & ~m_pb[7:6]), m_pb[9:0]});
            `SPM_SER_CTRL: erd = 32'(m_sc);
            `SPM_STATUS: erd = 32'({m_sc[0], m_bdm});
            `SPM_PA_IN: erd = m_sc[0] ? 32'(port_a_in[2:0]) : 32'(port_a_in[3:0] & ~m_dir[3:0]);
            default: erd = 32'h0000_0000;
        endcase
    endfunction
    task rd(input logic [11:0] a);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        // Line four is output-only after the strap, so its input bit must read zero.
        chk("read", erd(a), r);
        chk("slverr", 32'h0000_0000, pslverr);
    endtask
    task do_reset(input logic v4);
        rst <= 1'b1;
        ext_val[4] <= 1'b0;
        ext_drv[4] <= ~v4;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        {m_dat, m_dir, m_we, m_sc} = 16'h0000;
        m_pe = 5'h10;
        m_ps = 5'h10;
        m_pb = 12'h030;
        m_bdm = ~v4;
        repeat (2) @(negedge clk);
        chk("line4 in", 32'h0000_0000, port_a_oe[4]);
        chk("b pullup", 32'h0000_0003, port_b_pu);
        repeat (12) @(negedge clk);
        chk("debug", m_bdm, background_debug_mode);
        chk("line4 out", 32'h0000_0001, port_a_oe[4]);
    endtask
    task check_pins;
        logic       s;
        logic [1:0] t, an, boe;
        logic [4:0] aoe;
        s = m_sc[0];
        t = m_pb[7:6];
        an = m_pb[9:8] & ~t;
        aoe = {1'b1, s ? {ser_data_out_en, 3'b000} : m_dir[3:0]};
        boe = ((t & timer_oe) | (~t & m_pb[3:2])) & ~an;
        chk("a oe", aoe, port_a_oe);
        chk("a out", aoe & {m_dat[4], s ? ser_data_out : m_dat[3], m_dat[2:0]},
            aoe & port_a_out);
        chk("a pu", m_pe & m_ps & ~aoe, port_a_pu);
        chk("a pd", s ? 0 : m_pe[3:0] & ~m_ps[3:0] & m_we & ~aoe[3:0], port_a_pd);
        chk("wake", s ? 0 : port_a_in[3:0] & m_we & ~m_dir[3:0], keyboard_wake_in);
        chk("irq", m_sc[1] & ~s & ~m_dir[0] & port_a_in[0], ext_irq_in);
        chk("ser", s ? port_a_in[2:0] : 3'b001, {ser_data_in, ser_clock, ser_select_n});
        chk("b oe", boe, port_b_oe);
        chk("b out", boe & ((t & timer_out) | (~t & m_pb[1:0])), boe & port_b_out);
        chk("b pu", m_pb[5:4] & ~boe & ~an, port_b_pu);
        chk("b pd", 32'h0000_0000, port_b_pd);
        chk("tmr in", port_b_in & t, timer_in);
        chk("adc", an, {analog_channel_four_sel, analog_channel_three_sel});
    endtask
    task rand_phase;
        logic [31:0] r;
        for (int k = 0; k < 40; k++)
        begin
            for (int j = 0; j < 7; j++)
                wr(12'(4 * j), $random(seed));
            r = $random(seed);
            @(posedge clk);
            ext_val <= r[6:0];
            ext_drv <= 7'h7f;
            {ser_data_out, ser_data_out_en, timer_out, timer_oe} <= r[19:14];
            @(negedge clk);
            check_pins;
            for (int j = 0; j < 10; j++)
                rd(12'(4 * j));
        end
    endtask
    // Strap low then high, with traffic after each reset.
    initial
    begin
        do_reset(1'b0);
        rand_phase;
        do_reset(1'b1);
        rand_phase;
        final_report;
    end
endmodule // sensor_port_pin_mux_tb
`default_nettype wire
